// File: pkg/ocf_pkg.sv
// package: command codes, field layout, reset values and types of the block
package ocf_pkg;

	// -------------------------------------------------------------
	// command codes of the two registers
	// -------------------------------------------------------------
	localparam logic [7:0]  CMD_THRESH  = 8'h46; // threshold, word access
	localparam logic [7:0]  CMD_ACTION  = 8'h47; // response, byte access

	// -------------------------------------------------------------
	// reset values (none published, safe defaults)
	// -------------------------------------------------------------
	localparam logic [15:0] THRESH_RST  = 16'h0000;
	localparam logic [7:0]  ACTION_RST  = 8'hc0; // shut down, no restart
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;

	// -------------------------------------------------------------
	// field positions inside the response byte
	// -------------------------------------------------------------
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI   = 2;
	localparam int DLY_LO   = 0;
	localparam int BYTE_W   = 8;

	// -------------------------------------------------------------
	// retry field codes and widths
	// -------------------------------------------------------------
	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam int         DLY_CNT_W     = 8; // holds 128 units
	localparam int         SYNC_STAGES   = 2;

	// response chosen when the current limit is reached
	typedef enum logic [1:0] {
		RESP_BRICKWALL = 2'b00,
		RESP_COND_CC   = 2'b01,
		RESP_DELAY_CC  = 2'b10,
		RESP_SHUTDOWN  = 2'b11
	} ocf_resp_type;

	// fault handler states
	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_RUN   = 3'b001,
		ST_LIMIT = 3'b010,
		ST_WAIT  = 3'b011,
		ST_LATCH = 3'b100
	} ocf_state_type;

endpackage : ocf_pkg

// File: pkg/ocf_timer_if.sv
// interface: start and expiry of the delay timer
`timescale 1ns/10ps
interface ocf_timer_if;
	logic       start; // one-cycle pulse, loads a new delay
	logic [2:0] expo;  // delay field, count is two to this power
	logic       done;  // one-cycle pulse when the delay has run out

	modport ctrl  (output start, output expo, input done);
	modport timer (input start, input expo, output done);
endinterface : ocf_timer_if

// File: design/ocf_sync.sv
// module: two-stage synchroniser for asynchronous analog flags
`timescale 1ns/10ps
module ocf_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic [W-1:0] i_async,
	output      logic [W-1:0] o_sync
);
	import ocf_pkg::*;

	// -------------------------------------------------------------
	// elaboration check
	// -------------------------------------------------------------
	if (W < 1) begin : g_bad_w
		$error("ocf_sync: width must be at least one");
	end

	// -------------------------------------------------------------
	// one two-flop chain per bit; stage one feeds stage two only
	// -------------------------------------------------------------
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic [SYNC_STAGES-1:0] meta_r; // [0] may be metastable
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				meta_r <= '0;
			end else begin
				meta_r <= {meta_r[0], i_async[b]};
			end
		end
		assign o_sync[b] = meta_r[SYNC_STAGES-1];
	end
endmodule : ocf_sync

// File: design/ocf_delay_timer.sv
// module: counts two-to-the-n delay units, then pulses done
`timescale 1ns/10ps
module ocf_delay_timer (
	input  wire logic   i_clk,
	input  wire logic   i_sys_rst,
	input  wire logic   i_unit_tick,
	ocf_timer_if.timer  tmr
);
	import ocf_pkg::*;

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [DLY_CNT_W-1:0] cnt_r;    // units seen so far
	logic [DLY_CNT_W-1:0] target_r; // units to wait
	logic                 run_r;    // timer armed
	logic                 done_r;   // expiry pulse

	// field value n gives 2**n units, 1 up to 128
	function automatic logic [DLY_CNT_W-1:0] units_of(input logic [2:0] n);
		units_of = DLY_CNT_W'(1) << n;
	endfunction : units_of

	wire last_unit = run_r && i_unit_tick && (cnt_r + 1'b1 == target_r);

	// -------------------------------------------------------------
	// counter; a new start always wins over a running delay
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_r    <= '0;
			target_r <= '0;
			run_r    <= 1'b0;
			done_r   <= 1'b0;
		end else if (tmr.start) begin
			cnt_r    <= '0;
			target_r <= units_of(tmr.expo);
			run_r    <= 1'b1;
			done_r   <= 1'b0;
		end else begin
			done_r <= last_unit;
			if (last_unit) begin
				run_r <= 1'b0;
			end else if (run_r && i_unit_tick) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	assign tmr.done = done_r;

	chk_dly_target: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		tmr.start |=> target_r == (DLY_CNT_W'(1) << $past(tmr.expo)))
		else $error("delay target is not two to the field");
endmodule : ocf_delay_timer

// File: design/ocf_overcurrent.sv
// module: output over-current fault response with its two registers
`timescale 1ns/10ps

module ocf_overcurrent (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_oc_detect,       // comparator, async
	input  wire logic        i_vout_below_floor, // async
	input  wire logic        i_output_on_cmd,   // pin and command
	input  wire logic        i_clear_faults,    // pulse
	input  wire logic        i_other_fault_off, // pulse
	input  wire logic        i_unit_tick,       // one delay unit
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic        i_wr_stb,
	input  wire logic [15:0] i_wr_data,
	input  wire logic        i_rd_stb,
	output      logic [15:0] o_rd_data,
	output      logic        o_rd_valid,
	output      logic        o_out_enable,
	output      logic        o_current_limit,
	output      logic [15:0] o_limit_value,
	output      logic        o_oc_status,
	output      logic        o_alert,
	output      logic [2:0]  o_retries_used
);
	import ocf_pkg::*;

	// -------------------------------------------------------------
	// registers and state
	// -------------------------------------------------------------
	logic [15:0]          thresh_r;     // limit, linear format
	logic [7:0]           action_r;     // response byte
	ocf_state_type        state_r;      // handler state
	ocf_state_type        state_nxt;
	logic [2:0]           tries_r;      // restarts spent
	logic [2:0]           tries_nxt;
	logic                 status_r;     // sticky fault bit
	logic                 alert_r;      // notification pulse
	logic                 en_d_r;       // last on-command level
	logic [15:0]          rd_data_r;
	logic                 rd_valid_r;
	logic                 fault_evt;    // new fault this cycle
	logic                 tmr_start;
	logic [1:0]           pins_s;       // synchronised flags

	ocf_timer_if tmr_bus ();

	// -------------------------------------------------------------
	// pin synchroniser and delay timer
	// -------------------------------------------------------------
	ocf_sync #(
		.W (2)
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_vout_below_floor, i_oc_detect}),
		.o_sync    (pins_s)
	);

	// unit length set elsewhere; only its tick arrives here
	ocf_delay_timer u_timer (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_unit_tick (i_unit_tick),
		.tmr         (tmr_bus.timer)
	);

	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	wire       oc_s       = pins_s[0];
	wire       uv_s       = pins_s[1];
	wire       hit_thresh = (i_cmd_code == CMD_THRESH);
	wire       hit_action = (i_cmd_code == CMD_ACTION);
	wire       wr_thresh  = i_wr_stb && hit_thresh;
	wire       wr_action  = i_wr_stb && hit_action;
	wire [1:0] resp_raw   = action_r[RESP_HI:RESP_LO];
	wire [2:0] retry_fld  = action_r[RETRY_HI:RETRY_LO];
	wire [2:0] dly_fld    = action_r[DLY_HI:DLY_LO];
	ocf_resp_type resp;
	assign resp = ocf_resp_type'(resp_raw);
	wire       en_rise    = i_output_on_cmd && !en_d_r;
	wire       tmr_done   = tmr_bus.done;

	// retries left: unlimited at 111, none at 000
	wire forever_try = (retry_fld == RETRY_FOREVER);
	wire tries_left  = forever_try ||
		((retry_fld != RETRY_NONE) && (tries_r < retry_fld));

	// shutdown demanded by the selected response
	wire shut_now  = (state_r == ST_RUN) && oc_s &&
		(resp == RESP_SHUTDOWN);
	wire shut_uv   = (state_r == ST_LIMIT) &&
		(resp == RESP_COND_CC) && uv_s;
	wire shut_dly  = (state_r == ST_LIMIT) &&
		(resp == RESP_DELAY_CC) && tmr_done && oc_s;
	wire shut_req  = shut_now || shut_uv || shut_dly;

	// read mux; unmapped codes answer zero
	wire [15:0] rd_mux = hit_thresh ? thresh_r :
		hit_action ? {{(16-BYTE_W){1'b0}}, action_r} : RD_UNMAPPED;

	// -------------------------------------------------------------
	// command registers
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			thresh_r <= THRESH_RST;
			action_r <= ACTION_RST;
		end else begin
			if (wr_thresh) begin
				thresh_r <= i_wr_data;
			end
			if (wr_action) begin
				action_r <= i_wr_data[BYTE_W-1:0];
			end
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rd_data_r  <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= i_rd_stb;
			if (i_rd_stb) begin
				rd_data_r <= rd_mux;
			end
		end
	end

	// -------------------------------------------------------------
	// fault handler next state
	// -------------------------------------------------------------
	// the on-command and a foreign shutdown override every state,
	// so an unlimited retry loop still ends on either of them
	always_comb begin
		state_nxt = state_r;
		tries_nxt = tries_r;
		tmr_start = 1'b0;
		fault_evt = 1'b0;
		if (!i_output_on_cmd) begin
			state_nxt = ST_OFF;
		end else if (i_other_fault_off) begin
			state_nxt = ST_LATCH;
		end else begin
			case (state_r)
				ST_OFF: begin
					state_nxt = ST_RUN;
				end
				ST_RUN: begin
					if (oc_s) begin
						fault_evt = 1'b1;
						if (!shut_req) begin
							// 00, 01 and 10 all start by limiting
							state_nxt = ST_LIMIT;
							tmr_start = (resp == RESP_DELAY_CC);
						end
					end
				end
				ST_LIMIT: begin
					if (!shut_req && !oc_s) begin
						state_nxt = ST_RUN;
					end
				end
				ST_WAIT: begin
					if (tmr_done) begin
						state_nxt = ST_RUN;
					end
				end
				ST_LATCH: begin
					if (i_clear_faults) begin
						state_nxt = ST_RUN;
					end
				end
				default: begin
					state_nxt = ST_OFF;
				end
			endcase
			// common shutdown path: wait and retry, or stay off
			if (shut_req) begin
				if (tries_left) begin
					state_nxt = ST_WAIT;
					tmr_start = 1'b1;
					if (!forever_try) begin
						tries_nxt = tries_r + 1'b1;
					end
				end else begin
					state_nxt = ST_LATCH;
				end
			end
		end
		if (i_clear_faults || en_rise) begin
			tries_nxt = '0;
		end
	end

	assign tmr_bus.start = tmr_start;
	assign tmr_bus.expo  = dly_fld;

	// -------------------------------------------------------------
	// state, status and notification flops
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r  <= ST_OFF;
			tries_r  <= '0;
			status_r <= 1'b0;
			alert_r  <= 1'b0;
			en_d_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			tries_r  <= tries_nxt;
			en_d_r   <= i_output_on_cmd;
			// a fault in the clearing cycle is kept
			status_r <= fault_evt || (status_r && !i_clear_faults);
			alert_r  <= fault_evt;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign o_out_enable    = (state_r == ST_RUN) || (state_r == ST_LIMIT);
	assign o_current_limit = (state_r == ST_LIMIT);
	assign o_limit_value   = thresh_r;
	assign o_oc_status     = status_r;
	assign o_alert         = alert_r;
	assign o_retries_used  = tries_r;
	assign o_rd_data       = rd_data_r;
	assign o_rd_valid      = rd_valid_r;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	sequence s_keep_on;
		i_output_on_cmd && !i_other_fault_off;
	endsequence
	sequence s_delay_expired;
		state_r == ST_LIMIT && resp == RESP_DELAY_CC && tmr_done && oc_s;
	endsequence

	chk_fault_notify: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		fault_evt |=> o_alert && o_oc_status)
		else $error("fault not flagged or not notified");
	chk_status_sticky: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		o_oc_status && !i_clear_faults |=> o_oc_status)
		else $error("status bit dropped without clear");
	chk_brickwall_hold: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		state_r == ST_LIMIT && resp == RESP_BRICKWALL && oc_s
		and s_keep_on |=> o_current_limit && o_out_enable)
		else $error("brickwall limiting left");
	chk_cond_floor: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		state_r == ST_LIMIT && resp == RESP_COND_CC && !uv_s && oc_s
		and s_keep_on |=> o_out_enable)
		else $error("conditioned limit stopped above floor");
	chk_cond_uv_off: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		shut_uv && i_output_on_cmd |=> !o_out_enable)
		else $error("no shutdown below voltage floor");
	chk_delay_retry: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		s_delay_expired and s_keep_on |=> !o_out_enable)
		else $error("delayed limit did not shut down");
	chk_immediate_off: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		shut_now and s_keep_on |=> !o_out_enable ##1 !o_out_enable)
		else $error("immediate shutdown missing");
	chk_no_retry: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		shut_req && retry_fld == RETRY_NONE and s_keep_on
		|=> state_r == ST_LATCH)
		else $error("restart attempted with retry zero");
	chk_retry_spent: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		shut_req && !forever_try && tries_r >= retry_fld and s_keep_on
		|=> state_r == ST_LATCH)
		else $error("retries exceeded the field");
	chk_retry_forever: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		shut_req && forever_try and s_keep_on |=> state_r == ST_WAIT)
		else $error("unlimited retry stopped");
	chk_wait_restart: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		state_r == ST_WAIT && tmr_done and s_keep_on |=> o_out_enable)
		else $error("restart not taken after delay");
	chk_tries_refill: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		i_clear_faults || en_rise |=> o_retries_used == 3'h0)
		else $error("retry allowance not refilled");
endmodule : ocf_overcurrent

// File: sim/ocf_load_model.sv
// model of the power stage and load that sit beside the fault block
`timescale 1ns/10ps
// -------------------------------------------------------------
// power stage, load and delay unit source
// -------------------------------------------------------------
module ocf_load_model #(
	parameter int TICK_DIV = 10 // clock cycles per delay unit, plain default
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_out_enable,
	input  wire logic i_short,
	input  wire logic i_sag,
	output      logic o_oc_detect,
	output      logic o_vout_below_floor,
	output      logic o_unit_tick
);
	int tick_cnt; // divides the clock down to one delay unit

	// a shorted load only draws over-current while the stage is on
	assign o_oc_detect        = i_short & i_out_enable;
	// a dead stage cannot sag, so the floor flag follows the enable too
	assign o_vout_below_floor = i_sag & i_out_enable;

	// free-running unit source, its length is set outside the block
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || tick_cnt == TICK_DIV - 1) begin
			tick_cnt <= 0;
		end else begin
			tick_cnt <= tick_cnt + 1;
		end
	end
	assign o_unit_tick = (tick_cnt == TICK_DIV - 1); // one cycle a unit
endmodule : ocf_load_model

// File: sim/ocf_overcurrent_bench.sv
// self-checking bench of the over-current fault block
`timescale 1ns/10ps
module ocf_overcurrent_bench;
	import ocf_pkg::*;
	// -------------------------------------------------------------
	// signals
	// -------------------------------------------------------------
	localparam int P = 10;   // cycles per delay unit in the model
	logic        i_clk   = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        on_cmd  = 1'b0; // output commanded on
	logic        clr     = 1'b0; // clear faults pulse
	logic        other   = 1'b0; // other fault forces shutdown
	logic        short_l = 1'b0; // load shorted
	logic        sag     = 1'b0; // output pulled below floor
	logic [7:0]  cmd     = 8'h00;
	logic        wr      = 1'b0;
	logic [15:0] wdat    = 16'h0000;
	logic        rd      = 1'b0;
	logic        oc, below, tick, rd_valid, out_en, cur_lim, oc_stat, alert;
	logic [15:0] rd_data, lim_val;
	logic [2:0]  retries;
	logic        was_en; // previous enable, to count restarts
	int          error_cnt = 0;
	int          compares  = 0;
	int          n, r, d, ups;

	always #2 i_clk = ~i_clk; // 250 MHz

	// -------------------------------------------------------------
	// design and far side
	// -------------------------------------------------------------
	ocf_overcurrent i_ocf_overcurrent (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_oc_detect(oc),
		.i_vout_below_floor(below), .i_output_on_cmd(on_cmd),
		.i_clear_faults(clr), .i_other_fault_off(other),
		.i_unit_tick(tick), .i_cmd_code(cmd), .i_wr_stb(wr),
		.i_wr_data(wdat), .i_rd_stb(rd), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_out_enable(out_en),
		.o_current_limit(cur_lim), .o_limit_value(lim_val),
		.o_oc_status(oc_stat), .o_alert(alert), .o_retries_used(retries)
	);
	ocf_load_model #(.TICK_DIV(P)) i_ocf_load_model (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_out_enable(out_en),
		.i_short(short_l), .i_sag(sag), .o_oc_detect(oc),
		.o_vout_below_floor(below), .o_unit_tick(tick)
	);

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	// verdict and end of run, also reached when a wait runs out
	task automatic close_out();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	// write strobe stands for exactly one edge
	task automatic reg_wr(input logic [7:0] code, input logic [15:0] data);
		@(negedge i_clk);
		cmd  = code;
		wdat = data;
		wr   = 1'b1;
		@(negedge i_clk);
		wr   = 1'b0;
	endtask : reg_wr

	// read strobe for one edge, then a bounded wait for the valid pulse
	task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp);
		int i;
		@(negedge i_clk);
		cmd = code;
		rd  = 1'b1;
		@(negedge i_clk);
		rd  = 1'b0;
		for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge i_clk);
		check(rd_valid === 1'b1 && rd_data === exp, "read data mismatch");
		// a read that never answers is a hang: report and stop
		if (rd_valid !== 1'b1) begin
			close_out();
		end
	endtask : reg_rd

	// wait for alert (0), enable (1) or limiting (2) to reach a level
	task automatic wait_on(input int sel, input logic val, input int lim,
			output int cnt);
		logic s;
		for (cnt = 1; cnt <= lim; cnt++) begin
			@(negedge i_clk);
			s = (sel == 0) ? alert : (sel == 1) ? out_en : cur_lim;
			if (s === val) return;
		end
		check(1'b0, "wait bound ran out");
		close_out();
	endtask : wait_on

	task automatic pulse_clear();
		@(negedge i_clk);
		clr = 1'b1;
		@(negedge i_clk);
		clr = 1'b0;
	endtask : pulse_clear

	// new response byte, faults cleared, output switched off and on again
	task automatic fresh(input logic [7:0] act);
		@(negedge i_clk);
		short_l = 1'b0;
		sag     = 1'b0;
		on_cmd  = 1'b0;
		reg_wr(CMD_ACTION, {8'h00, act});
		pulse_clear();
		on_cmd  = 1'b1;
		wait_on(1, 1'b1, 10, n);
	endtask : fresh

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (10) @(negedge i_clk);
		i_sys_rst = 1'b0;
		// registers: reset values, widths, unmapped code
		reg_rd(CMD_THRESH, 16'h0000);
		reg_rd(CMD_ACTION, 16'h00c0);
		reg_wr(CMD_THRESH, 16'hbeef);
		reg_rd(CMD_THRESH, 16'hbeef);
		check(lim_val === 16'hbeef, "limit value");
		reg_wr(CMD_ACTION, 16'hfff9);
		reg_rd(CMD_ACTION, 16'h00f9);
		reg_rd(8'h48, RD_UNMAPPED);
		// shutdown, retry once, four units between attempts
		fresh(8'hca);
		short_l = 1'b1;
		wait_on(0, 1'b1, 10, n);
		check(oc_stat === 1'b1 && out_en === 1'b0, "shutdown");
		wait_on(1, 1'b1, 6 * P, n);
		check(n >= 3 * P && n <= 4 * P + 4, "restart spacing");
		repeat (8 * P) @(negedge i_clk);
		check(out_en === 1'b0 && retries === 3'h1, "latched off");
		short_l = 1'b0;
		pulse_clear();
		wait_on(1, 1'b1, 10, n);
		check(retries === 3'h0 && oc_stat === 1'b0, "clear refill");
		// every retry code, counted in restarts seen at the enable
		for (r = 0; r < 8; r++) begin
			fresh({2'b11, r[2:0], 3'h0});
			short_l = 1'b1;
			ups     = 0;
			was_en  = 1'b1;
			repeat (20 * P) begin
				@(negedge i_clk);
				if (out_en === 1'b1 && was_en === 1'b0) ups++;
				was_en = out_en;
			end
			if (r == 7) begin
				check(ups > 6 && retries === 3'h0, "endless retry");
			end else begin
				check(ups == r && out_en === 1'b0, "retry count");
			end
		end
		// another fault ends endless retrying
		@(negedge i_clk);
		other = 1'b1;
		@(negedge i_clk);
		other = 1'b0;
		repeat (5 * P) @(negedge i_clk);
		check(out_en === 1'b0, "other fault off");
		// brickwall limiting runs on
		fresh(8'h00);
		short_l = 1'b1;
		wait_on(2, 1'b1, 10, n);
		repeat (300) @(negedge i_clk);
		check(out_en === 1'b1 && cur_lim === 1'b1, "brickwall");
		check(oc_stat === 1'b1, "status");
		short_l = 1'b0;
		wait_on(2, 1'b0, 10, n);
		// conditioned limiting, floor breached, no retry
		fresh(8'h40);
		short_l = 1'b1;
		wait_on(2, 1'b1, 10, n);
		repeat (50) @(negedge i_clk);
		check(out_en === 1'b1, "limit above floor");
		sag = 1'b1;
		wait_on(1, 1'b0, 8, n);
		repeat (5 * P) @(negedge i_clk);
		check(out_en === 1'b0, "stays off");
		// delayed limiting, then shutdown, three delay codes
		for (d = 0; d < 8; d += 3) begin
			fresh({5'h10, d[2:0]});
			short_l = 1'b1;
			wait_on(2, 1'b1, 10, n);
			wait_on(1, 1'b0, ((1 << d) + 2) * P, n);
			check(n >= ((1 << d) - 1) * P &&
				n <= (1 << d) * P + 6, "delay");
		end
		close_out();
	end
endmodule : ocf_overcurrent_bench
